/* File: hw/rstc_pkg.sv */
package rstc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register word indices on the avalon-mm slave
    localparam logic [3:0] REG_STATUS     = 4'h0;
    localparam logic [3:0] REG_CONFIG     = 4'h1;
    localparam logic [3:0] REG_FLAG_CTRL  = 4'h2;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h3;
    localparam logic [3:0] REG_IRQ_MASK   = 4'h4;
    localparam int         ADDR_W         = 6;
    localparam int         DATA_W         = 32;

    ////////////////////////////////////////////////////////////////////////
    // status register fields (read only)
    localparam int STAT_TO_BIT    = 0;
    localparam int STAT_PD_BIT    = 1;
    localparam int STAT_STATE_LSB = 2;
    localparam int STAT_KIND_LSB  = 4;
    localparam int STAT_LV_BIT    = 6;
    localparam int STAT_PIN_BIT   = 7;

    // config register fields
    localparam int CFG_LV_EN_BIT  = 0;
    localparam int CFG_THR_LSB    = 1;
    localparam int THR_W          = 2;

    // flag control: writing a one clears the flag
    localparam int FCTL_CLR_TO_BIT = 0;
    localparam int FCTL_CLR_PD_BIT = 1;

    // interrupt status / mask layout, one bit per reset source
    localparam int EVT_PIN      = 0;
    localparam int EVT_LOW_VOLT = 1;
    localparam int EVT_WDT_RUN  = 2;
    localparam int EVT_WDT_HALT = 3;
    localparam int EVT_W        = 4;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic             CFG_LV_EN_RST = 1'b0;
    localparam logic [THR_W-1:0] CFG_THR_RST   = 2'h0;
    localparam logic [EVT_W-1:0] IRQ_MASK_RST  = 4'h0;
    localparam logic [7:0]       PORT_RST_VAL  = 8'hff;
    localparam logic [7:0]       PC_LOW_RST    = 8'h00;
    localparam logic [THR_W-1:0] THR_MAX_SEL   = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ             = 100;
    localparam int LV_MIN_DURATION_US  = 1000;
    localparam int LV_MIN_CYCLES       = LV_MIN_DURATION_US * CLK_MHZ;
    localparam int RELEASE_DELAY_US    = 100;
    localparam int RELEASE_CYCLES      = RELEASE_DELAY_US * CLK_MHZ;
    localparam int CNT_W               = 20;

    ////////////////////////////////////////////////////////////////////////
    // sequencer states and reset kinds
    typedef enum logic [1:0] {
        ST_RUN,
        ST_HOLD,
        ST_DELAY
    } rstc_state_t;

    typedef enum logic [1:0] {
        KIND_POWER_ON,
        KIND_PIN_LV,
        KIND_WDT_RUN,
        KIND_WDT_HALT
    } rstc_kind_t;

    // initial conditions driven towards the core and peripherals
    typedef struct packed {
        logic       core_hold;
        logic       pc_sp_clear;
        logic       intr_disable;
        logic       timers_off;
        logic       prescaler_clear;
        logic       ports_to_input;
        logic       wdt_clear;
        logic [7:0] port_init;
        logic [7:0] pc_low_init;
    } rstc_init_t;

    typedef struct packed {
        logic             lv_en;
        logic [THR_W-1:0] thr_sel;
    } rstc_cfg_t;

endpackage : rstc_pkg

/* File: hw/rstc_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module rstc_sync #(
    parameter int          WIDTH    = 2,
    parameter logic [1:0]  RST_VAL  = 2'h3
) (
    input  wire logic             clock_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    for (genvar g = 0; g < WIDTH; g++) begin : g_bit
        always_ff @(posedge clock_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                meta[g]   <= RST_VAL[g];
                sync_o[g] <= RST_VAL[g];
            end else begin
                meta[g]   <= async_i[g];
                sync_o[g] <= meta[g];
            end
        end
    end

endmodule : rstc_sync

`default_nettype wire

/* File: hw/rstc_top.sv */
// How it works
// - pin pulled low while running restarts execution from address zero.
// - low-voltage reset works only when enabled; acts like a pin reset.
// - low supply lasting up to 1ms is ignored; longer triggers reset.
// - reset threshold picked from a fixed set, paired with detect level.
// - watchdog time-out while running resets like the pin, sets time-out.
// - watchdog time-out in power-down clears only program counter, stack, watchdog.
// - time-out and power-down flags kept in status for software.
// - power-on reset clears both time-out and power-down flags.
// - pin or low-voltage reset leaves both flags unchanged.
// - running watchdog time-out sets time-out, keeps power-down flag.
// - watchdog time-out in power-down sets both flags.
// - after power-on every interrupt stays disabled until software.
// - watchdog counter cleared by reset and counts right after release.
// - reset turns timers off and clears the timer prescaler except halted watchdog time-out.
// - reset loads ports with all ones except halted watchdog time-out.
// - reset points the stack pointer at the top of the stack.
// - initial values follow reset kind; program counter low byte zero.
// - after pin release wait a start-up delay before running.
`timescale 1ns/100ps
`default_nettype none

module rstc_top
    import rstc_pkg::*;
#(
    parameter int LV_MIN_CYC  = LV_MIN_CYCLES,
    parameter int RELEASE_CYC = RELEASE_CYCLES
) (
    input  wire logic              clock_i,
    input  wire logic              rst_b_i,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [DATA_W-1:0] avs_writedata_i,
    output logic      [DATA_W-1:0] avs_readdata_o,
    output logic                   avs_waitrequest_o,
    // reset sources
    input  wire logic              ext_reset_n_pin_i,
    input  wire logic              low_volt_raw_i,
    input  wire logic              wdt_timeout_i,
    input  wire logic              halted_i,
    input  wire logic              powerdown_entry_i,
    // results
    output rstc_init_t             init_o,
    output logic [THR_W-1:0]       low_volt_threshold_o,
    output logic [THR_W-1:0]       low_volt_detect_sel_o,
    output logic                   watchdog_timeout_flag_o,
    output logic                   powerdown_flag_o,
    output logic                   irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // synchronise pin and comparator
    logic [1:0] sync_q;
    logic       pin_low;
    logic       lv_level;

    rstc_sync #(
        .WIDTH   (2),
        .RST_VAL (2'h1)
    ) u_sync (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .async_i ({low_volt_raw_i, ext_reset_n_pin_i}),
        .sync_o  (sync_q)
    );

    assign pin_low  = !sync_q[0];
    assign lv_level = sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // configuration
    rstc_cfg_t cfg;
    logic      bus_req;
    logic      bus_done;
    logic      wr_hit;
    logic [3:0] word_idx;

    assign bus_req  = avs_read_i || avs_write_i;
    assign bus_done = bus_req && !avs_waitrequest_o;
    assign word_idx = avs_address_i[ADDR_W-1:2];
    assign wr_hit   = avs_write_i && bus_done;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg.lv_en   <= CFG_LV_EN_RST;
            cfg.thr_sel <= CFG_THR_RST;
        end else if (wr_hit && word_idx == REG_CONFIG) begin
            cfg.lv_en <= avs_writedata_i[CFG_LV_EN_BIT];
            // codes beyond the set fall back to the lowest pair
            if (avs_writedata_i[CFG_THR_LSB +: THR_W] > THR_MAX_SEL) begin
                cfg.thr_sel <= CFG_THR_RST;
            end else begin
                cfg.thr_sel <= avs_writedata_i[CFG_THR_LSB +: THR_W];
            end
        end
    end

    // reset and detect thresholds always travel as one pair
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            low_volt_threshold_o  <= CFG_THR_RST;
            low_volt_detect_sel_o <= CFG_THR_RST;
        end else begin
            low_volt_threshold_o  <= cfg.thr_sel;
            low_volt_detect_sel_o <= cfg.thr_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // low-voltage filter: a dip must outlast the minimum duration
    logic [CNT_W-1:0] lv_cnt;
    logic             lv_trip;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lv_cnt  <= '0;
            lv_trip <= 1'b0;
        end else if (!(cfg.lv_en && lv_level)) begin
            lv_cnt  <= '0;
            lv_trip <= 1'b0;
        end else if (lv_cnt < CNT_W'(LV_MIN_CYC)) begin
            lv_cnt  <= lv_cnt + 1'b1;
        end else begin
            lv_trip <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    rstc_state_t      state;
    rstc_state_t      next_state;
    rstc_kind_t       kind;
    rstc_kind_t       next_kind;
    logic [CNT_W-1:0] dly_cnt;
    logic             hard_src;
    logic             wdt_run;
    logic             wdt_halt;

    assign hard_src = pin_low || lv_trip;
    assign wdt_run  = wdt_timeout_i && !halted_i;
    assign wdt_halt = wdt_timeout_i && halted_i;

    always_comb begin
        next_state = state;
        next_kind  = kind;
        unique case (state)
            ST_RUN: begin
                if (hard_src) begin
                    next_state = ST_HOLD;
                    next_kind  = KIND_PIN_LV;
                end else if (wdt_run) begin
                    next_state = ST_DELAY;
                    next_kind  = KIND_WDT_RUN;
                end else if (wdt_halt) begin
                    next_state = ST_DELAY;
                    next_kind  = KIND_WDT_HALT;
                end
            end
            ST_HOLD: begin
                if (!hard_src) begin
                    next_state = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (hard_src) begin
                    next_state = ST_HOLD;
                    if (kind == KIND_WDT_HALT || kind == KIND_WDT_RUN) begin
                        next_kind = KIND_PIN_LV;
                    end
                end else if (dly_cnt >= CNT_W'(RELEASE_CYC - 1)) begin
                    next_state = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= ST_HOLD;
            kind  <= KIND_POWER_ON;
        end else begin
            state <= next_state;
            kind  <= next_kind;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dly_cnt <= '0;
        end else if (next_state != ST_DELAY || state != ST_DELAY) begin
            dly_cnt <= '0;
        end else begin
            dly_cnt <= dly_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // initial conditions; a halted watchdog wake only touches pc, sp and the watchdog clear
    logic next_hold;
    logic next_full;

    assign next_hold = next_state != ST_RUN;
    assign next_full = next_hold && next_kind != KIND_WDT_HALT;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            init_o.core_hold       <= 1'b1;
            init_o.pc_sp_clear     <= 1'b1;
            init_o.intr_disable    <= 1'b1;
            init_o.timers_off      <= 1'b1;
            init_o.prescaler_clear <= 1'b1;
            init_o.ports_to_input  <= 1'b1;
            init_o.wdt_clear       <= 1'b1;
            init_o.port_init       <= PORT_RST_VAL;
            init_o.pc_low_init     <= PC_LOW_RST;
        end else begin
            init_o.core_hold       <= next_hold;
            init_o.pc_sp_clear     <= next_hold;
            init_o.intr_disable    <= next_full;
            init_o.timers_off      <= next_full;
            init_o.prescaler_clear <= next_full;
            init_o.ports_to_input  <= next_full;
            // released with the core so the watchdog counts at once
            init_o.wdt_clear       <= next_hold;
            init_o.port_init       <= PORT_RST_VAL;
            init_o.pc_low_init     <= PC_LOW_RST;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset cause flags; set beats a software clear in the same cycle
    logic clr_to;
    logic clr_pd;

    assign clr_to = wr_hit && word_idx == REG_FLAG_CTRL
                    && avs_writedata_i[FCTL_CLR_TO_BIT];
    assign clr_pd = wr_hit && word_idx == REG_FLAG_CTRL
                    && avs_writedata_i[FCTL_CLR_PD_BIT];

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            watchdog_timeout_flag_o <= 1'b0;
        end else if (state == ST_RUN && wdt_timeout_i && !hard_src) begin
            watchdog_timeout_flag_o <= 1'b1;
        end else if (clr_to) begin
            watchdog_timeout_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            powerdown_flag_o <= 1'b0;
        end else if (state == ST_RUN && !hard_src
                     && (wdt_halt || powerdown_entry_i)) begin
            powerdown_flag_o <= 1'b1;
        end else if (clr_pd) begin
            powerdown_flag_o <= 1'b0;
        end
    end
    // pin and low-voltage resets never touch either flag

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, write one to clear, set wins
    logic [EVT_W-1:0] irq_status;
    logic [EVT_W-1:0] irq_mask;
    logic [EVT_W-1:0] evt;

    always_comb begin
        evt               = '0;
        evt[EVT_PIN]      = state == ST_RUN && pin_low;
        evt[EVT_LOW_VOLT] = state == ST_RUN && lv_trip && !pin_low;
        evt[EVT_WDT_RUN]  = state == ST_RUN && !hard_src && wdt_run;
        evt[EVT_WDT_HALT] = state == ST_RUN && !hard_src && wdt_halt;
    end

    for (genvar g = 0; g < EVT_W; g++) begin : g_irq
        always_ff @(posedge clock_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                irq_status[g] <= 1'b0;
            end else if (evt[g]) begin
                irq_status[g] <= 1'b1;
            end else if (wr_hit && word_idx == REG_IRQ_STATUS
                         && avs_writedata_i[g]) begin
                irq_status[g] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_mask <= IRQ_MASK_RST;
        end else if (wr_hit && word_idx == REG_IRQ_MASK) begin
            irq_mask <= avs_writedata_i[EVT_W-1:0];
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, data ready when waitrequest drops
    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        unique case (word_idx)
            REG_STATUS: begin
                rd_mux[STAT_TO_BIT]             = watchdog_timeout_flag_o;
                rd_mux[STAT_PD_BIT]             = powerdown_flag_o;
                rd_mux[STAT_STATE_LSB +: 2]     = state;
                rd_mux[STAT_KIND_LSB +: 2]      = kind;
                rd_mux[STAT_LV_BIT]             = lv_trip;
                rd_mux[STAT_PIN_BIT]            = pin_low;
            end
            REG_CONFIG: begin
                rd_mux[CFG_LV_EN_BIT]           = cfg.lv_en;
                rd_mux[CFG_THR_LSB +: THR_W]    = cfg.thr_sel;
            end
            REG_IRQ_STATUS: rd_mux[EVT_W-1:0]   = irq_status;
            REG_IRQ_MASK:   rd_mux[EVT_W-1:0]   = irq_mask;
            default:        rd_mux              = '0;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= '0;
        end else begin
            avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
            if (avs_read_i && avs_waitrequest_o) begin
                avs_readdata_o <= rd_mux;
            end
        end
    end

endmodule : rstc_top

`default_nettype wire

/* File: test/rstc_monitor.sv */
`timescale 1ns/100ps
`default_nettype none

module rstc_monitor
    import rstc_pkg::*;
#(
    parameter int RELEASE_CYC = 4
) (
    input  wire logic             clock_i,
    input  wire logic             rst_b_i,
    input  wire logic             ext_reset_n_pin_i,
    input  wire logic             wdt_timeout_i,
    input  wire logic             halted_i,
    input  wire logic             powerdown_entry_i,
    input  wire logic             avs_write_i,
    input  wire rstc_init_t       init_o,
    input  wire logic [THR_W-1:0] low_volt_threshold_o,
    input  wire logic [THR_W-1:0] low_volt_detect_sel_o,
    input  wire logic             watchdog_timeout_flag_o,
    input  wire logic             powerdown_flag_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    // length of the current core hold, to bound the start-up delay
    logic [15:0] hold_cnt;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) hold_cnt <= 16'h0;
        else if (init_o.core_hold) hold_cnt <= hold_cnt + 16'h1;
        else hold_cnt <= 16'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    property p_por_flags;
        $rose(rst_b_i) |-> !watchdog_timeout_flag_o && !powerdown_flag_o;
    endproperty
    a_por_flags: assert property (p_por_flags)
        else $error("flags not clear after power-on");
    property p_por_intr;
        $rose(rst_b_i) |-> init_o.intr_disable && init_o.ports_to_input;
    endproperty
    a_por_intr: assert property (p_por_intr)
        else $error("interrupts not disabled after power-on");
    property p_pin_flags;
        !ext_reset_n_pin_i && !wdt_timeout_i && !powerdown_entry_i
            && !avs_write_i |=> $stable(watchdog_timeout_flag_o)
            && $stable(powerdown_flag_o);
    endproperty
    a_pin_flags: assert property (p_pin_flags)
        else $error("pin reset changed a flag");
    property p_wdt_run;
        wdt_timeout_i && !halted_i && !init_o.core_hold && ext_reset_n_pin_i
            && !powerdown_entry_i |=> init_o.core_hold
            && init_o.ports_to_input && watchdog_timeout_flag_o
            && $stable(powerdown_flag_o);
    endproperty
    a_wdt_run: assert property (p_wdt_run)
        else $error("running time-out reset wrong");
    property p_wdt_halt;
        wdt_timeout_i && halted_i && !init_o.core_hold && ext_reset_n_pin_i
            |=> init_o.pc_sp_clear && !init_o.ports_to_input
            && watchdog_timeout_flag_o && powerdown_flag_o;
    endproperty
    a_wdt_halt: assert property (p_wdt_halt)
        else $error("halted time-out reset wrong");
    property p_pd_entry;
        powerdown_entry_i && !init_o.core_hold && ext_reset_n_pin_i
            |=> powerdown_flag_o;
    endproperty
    a_pd_entry: assert property (p_pd_entry)
        else $error("power-down flag not set on entry");
    property p_consts;
        init_o.pc_low_init == 8'h00 && init_o.port_init == 8'hff;
    endproperty
    a_consts: assert property (p_consts)
        else $error("initial byte values wrong");
    property p_thr_pair;
        low_volt_threshold_o == low_volt_detect_sel_o;
    endproperty
    a_thr_pair: assert property (p_thr_pair)
        else $error("threshold pair differs");
    property p_start_delay;
        $fell(init_o.core_hold) |-> hold_cnt >= RELEASE_CYC;
    endproperty
    a_start_delay: assert property (p_start_delay)
        else $error("core released before start-up delay");
    property p_wdt_clear;
        init_o.wdt_clear == init_o.core_hold;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear)
        else $error("watchdog clear not tied to hold");
endmodule : rstc_monitor

bind rstc_top rstc_monitor #(.RELEASE_CYC(RELEASE_CYC)) u_mon (
    .clock_i, .rst_b_i, .ext_reset_n_pin_i, .wdt_timeout_i, .halted_i,
    .powerdown_entry_i, .avs_write_i, .init_o, .low_volt_threshold_o,
    .low_volt_detect_sel_o, .watchdog_timeout_flag_o, .powerdown_flag_o
);

`default_nettype wire

/* File: test/rstc_switch_model.sv */
`timescale 1ns/100ps
`default_nettype none

// reset switch with pull-up: idle high, held low for hold_i cycles per press
module rstc_switch_model (
    input  wire logic       clock_i,
    input  wire logic       press_i,
    input  wire logic [7:0] hold_i,
    output logic            ext_reset_n_pin_o
);
    logic [7:0] cnt = 8'h0;
    always_ff @(posedge clock_i) begin
        if (press_i && cnt == 8'h0) cnt <= hold_i;
        else if (cnt != 8'h0) cnt <= cnt - 8'h1;
    end
    assign ext_reset_n_pin_o = (cnt == 8'h0);
endmodule : rstc_switch_model

`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/100ps
`default_nettype none

module tb
    import rstc_pkg::*;
;
    logic              clock_i = 1'b0;
    logic              rst_b_i, avs_read_i, avs_write_i;
    logic [ADDR_W-1:0] avs_address_i;
    logic [DATA_W-1:0] avs_writedata_i, avs_readdata_o;
    logic              avs_waitrequest_o, ext_reset_n_pin_i, low_volt_raw_i;
    logic              wdt_timeout_i, halted_i, powerdown_entry_i, press_i;
    logic [7:0]        hold_i;
    rstc_init_t        init_o;
    logic [THR_W-1:0]  thr, det;
    logic              to_flag, pd_flag, irq_o;
    int                mismatches = 0;
    int                total_checks = 0;

    always #5 clock_i = ~clock_i;

    rstc_top #(.LV_MIN_CYC(8), .RELEASE_CYC(4)) dut (
        .clock_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
        .ext_reset_n_pin_i, .low_volt_raw_i, .wdt_timeout_i, .halted_i,
        .powerdown_entry_i, .init_o, .low_volt_threshold_o(thr),
        .low_volt_detect_sel_o(det), .watchdog_timeout_flag_o(to_flag),
        .powerdown_flag_o(pd_flag), .irq_o);
    rstc_switch_model sw (.clock_i, .press_i, .hold_i,
        .ext_reset_n_pin_o(ext_reset_n_pin_i));

    ////////////////////////////////////////////////////////////////////////
    task print_verdict;
        if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            mismatches++;
        end
    endtask : chk

    // one avalon access; request held until waitrequest is sampled low
    task bus(input logic wr, input logic [3:0] r, input logic [31:0] wd,
             output logic [31:0] rd);
        int n;
        avs_address_i <= {r, 2'b00};
        avs_writedata_i <= wd;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 40);
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (avs_waitrequest_o !== 1'b0) begin
            mismatches++;
            print_verdict();
        end
        @(posedge clock_i);
    endtask : bus

    task wr(input logic [3:0] r, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, r, d, x);
    endtask : wr

    task rd_chk(input string nm, input logic [3:0] r, input logic [31:0] m,
                input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, r, 32'h0, x);
        chk(nm, exp, x & m);
    endtask : rd_chk

    task wait_hold(input logic lvl);
        int n;
        n = 0;
        while (init_o.core_hold !== lvl && n < 300) begin
            @(posedge clock_i);
            n++;
        end
        chk("core_hold", {31'h0, lvl}, {31'h0, init_o.core_hold});
        if (init_o.core_hold !== lvl) print_verdict();
    endtask : wait_hold

    task pulse_wdt;
        wdt_timeout_i <= 1'b1;
        @(posedge clock_i);
        wdt_timeout_i <= 1'b0;
    endtask : pulse_wdt

    ////////////////////////////////////////////////////////////////////////
    task s_power_on;
        chk("to_flag", 0, to_flag);
        chk("pd_flag", 0, pd_flag);
        chk("intr_disable", 1, init_o.intr_disable);
        wait_hold(1'b0);
        rd_chk("unmapped", 4'hf, 32'hffffffff, 32'h0);
        rd_chk("irq_mask", REG_IRQ_MASK, 32'hffffffff, 32'h0);
    endtask : s_power_on

    task s_wdt_run;
        pulse_wdt();
        wait_hold(1'b1);
        chk("ports_in", 1, init_o.ports_to_input);
        chk("to_flag", 1, to_flag);
        chk("pd_flag", 0, pd_flag);
        wait_hold(1'b0);
        rd_chk("status", REG_STATUS, 32'h3f, 32'h21);
    endtask : s_wdt_run

    task s_pin(input logic [7:0] len);
        logic t, p;
        t = to_flag;
        p = pd_flag;
        press_i <= 1'b1;
        hold_i <= len;
        @(posedge clock_i);
        press_i <= 1'b0;
        wait_hold(1'b1);
        chk("timers_off", 1, init_o.timers_off);
        chk("presc_clr", 1, init_o.prescaler_clear);
        chk("pc_sp_clear", 1, init_o.pc_sp_clear);
        chk("pc_low", 0, init_o.pc_low_init);
        chk("port_init", 32'hff, init_o.port_init);
        wait_hold(1'b0);
        chk("to_flag", t, to_flag);
        chk("pd_flag", p, pd_flag);
    endtask : s_pin

    task s_wdt_halt;
        powerdown_entry_i <= 1'b1;
        @(posedge clock_i);
        powerdown_entry_i <= 1'b0;
        halted_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        chk("pd_flag", 1, pd_flag);
        pulse_wdt();
        wait_hold(1'b1);
        chk("pc_sp_clear", 1, init_o.pc_sp_clear);
        chk("ports_in", 0, init_o.ports_to_input);
        chk("wdt_clear", 1, init_o.wdt_clear);
        chk("to_flag", 1, to_flag);
        chk("pd_flag", 1, pd_flag);
        wait_hold(1'b0);
        halted_i <= 1'b0;
        rd_chk("irq_status", REG_IRQ_STATUS, 32'hf, 32'hd);
    endtask : s_wdt_halt

    task s_irq_flags;
        wr(REG_IRQ_MASK, 32'h4);
        repeat (2) @(posedge clock_i);
        chk("irq", 1, irq_o);
        wr(REG_IRQ_STATUS, 32'h4);
        repeat (2) @(posedge clock_i);
        chk("irq", 0, irq_o);
        wr(REG_IRQ_MASK, 32'h0);
        wr(REG_IRQ_STATUS, 32'hf);
        wr(REG_FLAG_CTRL, 32'h3);
        rd_chk("flags", REG_STATUS, 32'h3, 32'h0);
    endtask : s_irq_flags

    task s_low_volt;
        low_volt_raw_i <= 1'b1;
        repeat (20) @(posedge clock_i);
        chk("lv_off", 0, init_o.core_hold);
        low_volt_raw_i <= 1'b0;
        wr(REG_CONFIG, 32'h7);
        rd_chk("cfg", REG_CONFIG, 32'h7, 32'h1);
        wr(REG_CONFIG, 32'h5);
        rd_chk("cfg", REG_CONFIG, 32'h7, 32'h5);
        chk("thr", 2, thr);
        chk("det", 2, det);
        low_volt_raw_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        low_volt_raw_i <= 1'b0;
        repeat (12) @(posedge clock_i);
        chk("lv_dip", 0, init_o.core_hold);
        low_volt_raw_i <= 1'b1;
        wait_hold(1'b1);
        low_volt_raw_i <= 1'b0;
        wait_hold(1'b0);
        chk("to_flag", 0, to_flag);
    endtask : s_low_volt

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b_i = 1'b0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_address_i = '0;
        avs_writedata_i = '0;
        low_volt_raw_i = 1'b0;
        wdt_timeout_i = 1'b0;
        halted_i = 1'b0;
        powerdown_entry_i = 1'b0;
        press_i = 1'b0;
        hold_i = 8'h0;
        repeat (2) @(posedge clock_i);
        rst_b_i <= 1'b1;
        @(posedge clock_i);
        s_power_on();
        s_wdt_run();
        s_pin(8'h06);
        s_wdt_halt();
        s_irq_flags();
        s_low_volt();
        s_pin(8'h28);
        print_verdict();
    end
endmodule : tb

`default_nettype wire
